// ### rtl/clock_gen_consts.vh
// Constants shared by the master clock generation block
`ifndef CLOCK_GEN_CONSTS_VH
`define CLOCK_GEN_CONSTS_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define OFS_CLOCK_GENERATOR_CONTROL 8'h00
`define OFS_SYSTEM_CONFIG_ONE 8'h04
`define OFS_CLOCK_STATUS 8'h08

// ************************************************************
// Control, config and status register field positions
// ************************************************************
`define MODE_LSB 0
`define MODE_MSB 1
`define IDIV_LSB 2
`define IDIV_MSB 3
`define ODIV_LSB 4
`define ODIV_MSB 7
`define MUL_LSB 8
`define MUL_MSB 12
`define HALVE_BIT 0
`define STAT_LOCK_BIT 0
`define STAT_PLL_BIT 1
`define STAT_MUL_LSB 8
`define STAT_MUL_MSB 12

// ************************************************************
// Field values, limits and reset values
// ************************************************************
`define MODE_PLL 2'h3
`define ODIV_MAX 4'he
`define MODE_RESET 2'h0
`define IDIV_RESET 2'h0
`define ODIV_RESET 4'h0
`define MUL_RESET 5'h00
`define HALVE_RESET 1'h0

// ************************************************************
// Timing: lock slew step
// ************************************************************
`define CLK_PERIOD_NS 4
`define SLEW_STEP_NS 1000
`define SLEW_STEP_CYCLES ((`SLEW_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### rtl/rate_accumulator.v
// Fractional rate generator producing one tick per output period
module rate_accumulator #(
    parameter NUM_W = 6,
    parameter DEN_W = 6
) (
    input wire sys_clk,
    input wire rstn,
    input wire [NUM_W-1:0] numerator,
    input wire [DEN_W-1:0] denominator,
    output reg tick
);
    localparam ACC_W = NUM_W + DEN_W + 1;

    reg [ACC_W-1:0] acc;
    reg [NUM_W-1:0] activeNum;
    reg [DEN_W-1:0] activeDen;
    reg [ACC_W-1:0] sum;
    reg [ACC_W-1:0] rem;
    reg next_tick;

    // ************************************************************
    // Accumulate and compare
    // ************************************************************
    always @* begin
        sum = acc + {{(ACC_W-NUM_W){1'b0}}, activeNum};
        next_tick = (sum >= {{(ACC_W-DEN_W){1'b0}}, activeDen});
        rem = next_tick ? (sum - {{(ACC_W-DEN_W){1'b0}}, activeDen}) : sum;
        // Saturate: above one tick per cycle the excess is dropped
        if (rem >= {{(ACC_W-DEN_W){1'b0}}, activeDen}) begin
            rem = {ACC_W{1'b0}};
        end
    end

    // New ratio taken only at a period boundary so no pulse is cut short
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            acc <= {ACC_W{1'b0}};
            activeNum <= {{(NUM_W-1){1'b0}}, 1'b1};
            activeDen <= {{(DEN_W-1){1'b0}}, 1'b1};
            tick <= 1'b0;
        end else begin
            tick <= next_tick;
            if (next_tick) begin
                // Remainder kept for an exact average rate; a new ratio restarts clean
                if (numerator == activeNum && denominator == activeDen) begin
                    acc <= rem;
                end else begin
                    acc <= {ACC_W{1'b0}};
                end
                activeNum <= numerator;
                activeDen <= denominator;
            end else begin
                acc <= rem;
            end
        end
    end
endmodule // rate_accumulator

// ### rtl/master_clock_generation.v
// Master, CPU and system clock generation with APB control registers
//
// How it works
// - A mode field other than 11 selects bypass, where only the two prescalers divide the input.
// - Bypass rate is the input rate over (input divider+1) times (output divider+1).
// - With both dividers zero the master tick is high every input cycle.
// - Input divider goes to 3 and output divider to 14, giving at most a divide by 60.
// - Mode 11 enables the loop path and it then supplies the master clock.
// - Loop rate is input times (multiplier+1) over (input div+1) times (output div+1).
// - The loop moves its multiplier one step at a time so a new multiplier never makes the rate jump; leaving mode 11 drops to bypass at once.
// - The CPU clock is the master clock or half of it, by one halve bit.
// - CPU, bus controller and peripherals share one rate, the CPU clock.
//
// The clocks leave as one-cycle enable ticks on sys_clk; a ratio above one
// tick per input cycle saturates at every cycle.
`include "clock_gen_consts.vh"

module master_clock_generation #(
    parameter ADDR_W = 8,
    parameter MUL_W = 5,
    parameter SLEW_CYCLES = `SLEW_STEP_CYCLES
) (
    input wire sys_clk,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire masterTick,
    output reg cpuTick,
    output reg sysTick,
    output reg pllLocked
);
    localparam NUM_W = MUL_W + 1;
    localparam DEN_W = 6;
    localparam SLEW_W = 16;

    // Software-visible settings
    reg [1:0] clockModeSelect;
    reg [1:0] inputDivider;
    reg [3:0] outputDivider;
    reg [MUL_W-1:0] multiplier;
    reg cpuClockHalve;

    // Derived clocking state
    reg [MUL_W-1:0] currentMul;
    reg [SLEW_W-1:0] slewCount;
    reg halveActive;
    reg cpuPhase;
    reg [NUM_W-1:0] ratioNum;
    reg [DEN_W-1:0] ratioDen;

    wire pllMode;
    wire setupRead;
    wire accessWrite;
    wire hitCtrl;
    wire hitCfg;
    wire hitStat;

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Output divider writes above the limit are clamped to it
    function [3:0] clampOdiv;
        input [3:0] value;
        begin
            clampOdiv = (value > `ODIV_MAX) ? `ODIV_MAX : value;
        end
    endfunction

    // Product of the two prescaler factors
    function [DEN_W-1:0] prescaleProduct;
        input [1:0] idiv;
        input [3:0] odiv;
        reg [DEN_W-1:0] a;
        reg [DEN_W-1:0] b;
        begin
            a = {{(DEN_W-2){1'b0}}, idiv} + {{(DEN_W-1){1'b0}}, 1'b1};
            b = {{(DEN_W-4){1'b0}}, odiv} + {{(DEN_W-1){1'b0}}, 1'b1};
            prescaleProduct = a * b;
        end
    endfunction

    // ************************************************************
    // APB slave
    // ************************************************************
    assign pllMode = (clockModeSelect == `MODE_PLL);
    assign hitCtrl = (paddr == `OFS_CLOCK_GENERATOR_CONTROL);
    assign hitCfg = (paddr == `OFS_SYSTEM_CONFIG_ONE);
    assign hitStat = (paddr == `OFS_CLOCK_STATUS);
    assign setupRead = psel & ~penable & ~pwrite;
    assign accessWrite = psel & penable & pwrite;
    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~(hitCtrl | hitCfg | hitStat);

    // Register writes, taken in the access phase
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clockModeSelect <= `MODE_RESET;
            inputDivider <= `IDIV_RESET;
            outputDivider <= `ODIV_RESET;
            multiplier <= `MUL_RESET;
            cpuClockHalve <= `HALVE_RESET;
        end else if (accessWrite) begin
            if (hitCtrl) begin
                clockModeSelect <= pwdata[`MODE_MSB:`MODE_LSB];
                inputDivider <= pwdata[`IDIV_MSB:`IDIV_LSB];
                outputDivider <= clampOdiv(pwdata[`ODIV_MSB:`ODIV_LSB]);
                multiplier <= pwdata[`MUL_MSB:`MUL_LSB];
            end else if (hitCfg) begin
                cpuClockHalve <= pwdata[`HALVE_BIT];
            end
        end
    end

    // Read data captured in the setup phase, held through the access
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h00000000;
        end else if (setupRead) begin
            prdata <= 32'h00000000;
            if (hitCtrl) begin
                prdata[`MODE_MSB:`MODE_LSB] <= clockModeSelect;
                prdata[`IDIV_MSB:`IDIV_LSB] <= inputDivider;
                prdata[`ODIV_MSB:`ODIV_LSB] <= outputDivider;
                prdata[`MUL_MSB:`MUL_LSB] <= multiplier;
            end else if (hitCfg) begin
                prdata[`HALVE_BIT] <= cpuClockHalve;
            end else if (hitStat) begin
                prdata[`STAT_LOCK_BIT] <= pllLocked;
                prdata[`STAT_PLL_BIT] <= pllMode;
                prdata[`STAT_MUL_MSB:`STAT_MUL_LSB] <= currentMul;
            end
        end
    end

    // ************************************************************
    // Loop multiplier slew
    // ************************************************************
    // One step per slew interval avoids an abrupt rate change; bypass
    // parks at zero so entering the loop starts at the bypass rate
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            currentMul <= {MUL_W{1'b0}};
            slewCount <= {SLEW_W{1'b0}};
            pllLocked <= 1'b0;
        end else begin
            pllLocked <= pllMode && (currentMul == multiplier);
            if (!pllMode) begin
                currentMul <= {MUL_W{1'b0}};
                slewCount <= {SLEW_W{1'b0}};
            end else if (currentMul == multiplier) begin
                slewCount <= {SLEW_W{1'b0}};
            end else if (slewCount >= SLEW_CYCLES[SLEW_W-1:0] - 1'b1) begin
                slewCount <= {SLEW_W{1'b0}};
                if (currentMul < multiplier) begin
                    currentMul <= currentMul + 1'b1;
                end else begin
                    currentMul <= currentMul - 1'b1;
                end
            end else begin
                slewCount <= slewCount + 1'b1;
            end
        end
    end

    // ************************************************************
    // Master clock ratio and generator
    // ************************************************************
    // Bypass uses a numerator of one; the loop uses the slewed multiplier
    always @* begin
        ratioDen = prescaleProduct(inputDivider, outputDivider);
        if (pllMode) begin
            ratioNum = {1'b0, currentMul} + {{(NUM_W-1){1'b0}}, 1'b1};
        end else begin
            ratioNum = {{(NUM_W-1){1'b0}}, 1'b1};
        end
    end

    // Ratio is latched inside only at the end of a master period
    rate_accumulator #(
        .NUM_W(NUM_W),
        .DEN_W(DEN_W)
    ) u_master_rate (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .numerator(ratioNum),
        .denominator(ratioDen),
        .tick(masterTick)
    );

    // ************************************************************
    // CPU and system clock ticks
    // ************************************************************
    // Halve setting switches only at a CPU period start, never mid-period
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            halveActive <= `HALVE_RESET;
            cpuPhase <= 1'b0;
            cpuTick <= 1'b0;
            sysTick <= 1'b0;
        end else begin
            cpuTick <= masterTick & (~halveActive | cpuPhase);
            sysTick <= masterTick & (~halveActive | cpuPhase);
            if (masterTick) begin
                if (halveActive & ~cpuPhase) begin
                    cpuPhase <= 1'b1;
                end else begin
                    cpuPhase <= 1'b0;
                    halveActive <= cpuClockHalve;
                end
            end
        end
    end
endmodule // master_clock_generation

// ### testbench/osc_source.sv
// Oscillator source model driving the block clock
module osc_source #(
    parameter real HALF_NS = 2.0
) (
    output logic oscClk
);
    timeunit 1ns;
    timeprecision 100ps;
    // Crystal runs free, so the clock never stops between accesses
    initial begin
        oscClk = 1'b0;
        forever #(HALF_NS) oscClk = ~oscClk;
    end
endmodule // osc_source

// ### testbench/master_clock_generation_sva.sv
// Port checker for the master clock generation block
`include "clock_gen_consts.vh"
module master_clock_generation_sva #(
    parameter ADDR_W = 8
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic masterTick,
    input wire logic cpuTick,
    input wire logic sysTick,
    input wire logic pllLocked
);
    logic [12:0] ctrl;
    logic halve;
    logic [7:0] calm;
    logic [7:0] gap;
    logic wr;
    logic byp;
    logic full;
    logic [7:0] divN;
    assign wr = psel && penable && pwrite && pready;
    assign byp = ctrl[1:0] != 2'h3;
    assign full = byp && ctrl[7:2] == 6'h00;
    // Top output divider code is clamped, so it divides like 14
    assign divN = ({6'h00, ctrl[3:2]} + 8'h01) * (ctrl[7:4] == 4'hf ? 8'h0f : ctrl[7:4] + 8'h01);
    // Shadow settings; calm counts master ticks since the last write, as
    // new ratios and the halve bit only apply at master period boundaries
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= 13'h0000;
            halve <= 1'h0;
            calm <= 8'h00;
            gap <= 8'h00;
        end else begin
            if (wr && paddr == `OFS_CLOCK_GENERATOR_CONTROL) ctrl <= pwdata[12:0];
            if (wr && paddr == `OFS_SYSTEM_CONFIG_ONE) halve <= pwdata[0];
            calm <= wr ? 8'h00 : ((calm == 8'hff || !masterTick) ? calm : calm + 8'h01);
            gap <= masterTick ? 8'h00 : gap + 8'h01;
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_sys_cpu_same: assert property (sysTick == cpuTick)
        else $error("system tick differs from cpu tick");
    a_cpu_after_master: assert property (cpuTick |-> $past(masterTick))
        else $error("cpu tick without master tick");
    a_bypass_unlocked: assert property (byp [*3] |-> !pllLocked)
        else $error("lock shown in bypass");
    a_lock_needs_pll: assert property ($rose(pllLocked) |-> !byp)
        else $error("lock rose outside loop mode");
    a_full_rate: assert property (full && !halve && calm > 8'h05 |-> masterTick && cpuTick)
        else $error("undivided clock missed a tick");
    a_half_cpu: assert property (full && halve && calm > 8'h05 && cpuTick |=> !cpuTick)
        else $error("halved cpu clock ticked twice");
    a_bypass_gap: assert property (byp && calm > 8'h02 && masterTick |-> gap + 8'h01 == divN)
        else $error("bypass master period wrong");
    a_reset_start: assert property ($rose(rstn) |=> masterTick ##1 cpuTick)
        else $error("clocks not undivided after reset");
endmodule // master_clock_generation_sva

// ### testbench/master_clock_generation_tb.sv
// Self-checking bench for the master clock generation block
`include "clock_gen_consts.vh"
module master_clock_generation_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic sysClk, rstn, psel, penable, pwrite, pready, pslverr, errSeen;
    logic masterTick, cpuTick, sysTick, pllLocked;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int fails = 0, checksDone = 0, cycles = 0, n;
    osc_source u_osc_source (.oscClk(sysClk));
    master_clock_generation #(.SLEW_CYCLES(2)) u_master_clock_generation (.sys_clk(sysClk),
        .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .masterTick(masterTick), .cpuTick(cpuTick), .sysTick(sysTick), .pllLocked(pllLocked));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sysClk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sysClk);
        penable <= 1'b1;
        @(posedge sysClk);
        while (pready !== 1'b1) @(posedge sysClk);
        rd = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Sampled on falling edges, clear of the tick updates
    task automatic period(input bit cpu, output int k);
        k = 0;
        do @(negedge sysClk); while ((cpu ? cpuTick : masterTick) !== 1'b1 && ++k < 200);
        k = 0;
        do begin
            @(negedge sysClk);
            k++;
        end while ((cpu ? cpuTick : masterTick) !== 1'b1 && k < 200);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic testReset();
        apb(1'b0, `OFS_CLOCK_GENERATOR_CONTROL, 32'h0);
        check("ctrl reset", rd, 32'h0);
        apb(1'b0, `OFS_SYSTEM_CONFIG_ONE, 32'h0);
        check("config reset", rd, 32'h0);
        apb(1'b0, 8'h0c, 32'h0);
        check("unmapped error", errSeen, 1'b1);
        check("unmapped data", rd, 32'h0);
    endtask
    task automatic testBypass();
        logic [31:0] cfg [5] = '{32'h0004, 32'h0022, 32'h00ec, 32'h00fd, 32'h1f01};
        int exp [5] = '{2, 3, 60, 60, 1};
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, `OFS_CLOCK_GENERATOR_CONTROL, cfg[k]);
            repeat (3) period(1'b0, n);
            check("bypass period", n, exp[k]);
        end
    endtask
    task automatic testHalve();
        apb(1'b1, `OFS_CLOCK_GENERATOR_CONTROL, 32'h0004);
        apb(1'b1, `OFS_SYSTEM_CONFIG_ONE, 32'h1);
        repeat (3) period(1'b1, n);
        check("halved cpu period", n, 4);
        apb(1'b1, `OFS_CLOCK_GENERATOR_CONTROL, 32'h0000);
        repeat (6) period(1'b1, n);
        check("halved full cpu period", n, 2);
        apb(1'b1, `OFS_CLOCK_GENERATOR_CONTROL, 32'h0004);
        apb(1'b1, `OFS_SYSTEM_CONFIG_ONE, 32'h0);
        repeat (3) period(1'b1, n);
        check("cpu period", n, 2);
    endtask
    // Loop mode: multiplier 3, output divider 7, so one tick in two cycles
    task automatic testPll();
        apb(1'b1, `OFS_CLOCK_GENERATOR_CONTROL, 32'h0373);
        apb(1'b0, `OFS_CLOCK_STATUS, 32'h0);
        check("early lock", rd[1:0], 2'h2);
        repeat (40) @(posedge sysClk);
        apb(1'b0, `OFS_CLOCK_STATUS, 32'h0);
        check("locked status", rd, 32'h0303);
        check("lock pin", pllLocked, 1'b1);
        repeat (3) period(1'b0, n);
        check("loop period", n, 2);
        apb(1'b1, `OFS_CLOCK_GENERATOR_CONTROL, 32'h0370);
        repeat (3) period(1'b0, n);
        check("back to bypass", n, 8);
    endtask
    // Hang guard well above the expected run length
    always @(posedge sysClk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge sysClk);
        rstn <= 1'b1;
        testReset();
        testBypass();
        testHalve();
        testPll();
        conclude();
    end
endmodule // master_clock_generation_tb
bind master_clock_generation master_clock_generation_sva #(.ADDR_W(ADDR_W)) u_sva (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .masterTick(masterTick),
    .cpuTick(cpuTick), .sysTick(sysTick), .pllLocked(pllLocked));
